// >>> rtl/ces_pkg.sv
package ces_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ          = 50000000;
	localparam int WDOG_TIMEOUT_S  = 175;
	// Slow timebase: one tick per millisecond
	localparam int TICK_PERIOD_MS  = 1;
	localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_PERIOD_MS;
	localparam int WDOG_TICKS      = WDOG_TIMEOUT_S * 1000 / TICK_PERIOD_MS;

	// ****************************************
	// Command codes and fields
	// ****************************************
	localparam logic [7:0] CMD_CHARGE_CURRENT = 8'h14;
	localparam logic [7:0] CMD_CHARGE_VOLTAGE = 8'h15;
	localparam int CUR_FIELD_LSB = 7;
	localparam int CUR_FIELD_MSB = 12;
	localparam int VOLT_FIELD_LSB = 4;
	localparam int VOLT_FIELD_MSB = 14;
	localparam logic [15:0] SETTING_RESET = 16'h0000;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		CES_IDLE,
		CES_ARMED,
		CES_CHARGING,
		CES_EXPIRED
	} ces_state_type;

endpackage

// >>> rtl/ces_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ces_sync (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Data
	input  wire logic [6:0] async,
	output var  logic [6:0] synced
);

	logic [6:0] stage;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			stage  <= 7'h00;
			synced <= 7'h00;
		end else begin
			stage  <= async;
			synced <= stage;
		end
	end

endmodule

`default_nettype wire

// >>> rtl/ces_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

module ces_watchdog #(
	parameter int TICK_CYCLES = ces_pkg::TICK_CYCLES,
	parameter int WDOG_TICKS  = ces_pkg::WDOG_TICKS
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Control
	input  wire logic kick,
	output var  logic expired
);

	logic [25:0] prescale;
	logic [24:0] ticks;
	logic        tick;

	assign tick = (prescale == 26'(TICK_CYCLES - 1));

	// ****************************************
	// Prescaler
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_b || kick || tick) begin
			prescale <= 26'h0000000;
		end else begin
			prescale <= prescale + 26'h0000001;
		end
	end

	// ****************************************
	// Timeout counter
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_b || kick) begin
			ticks   <= 25'h0000000;
			expired <= 1'b0;
		end else if (tick && !expired) begin
			if (ticks == 25'(WDOG_TICKS - 1)) begin
				expired <= 1'b1;
			end
			ticks <= ticks + 25'h0000001;
		end
	end

endmodule

`default_nettype wire

// >>> rtl/charge_enable_supervisor.sv
// Behaviour
// - Stop charging after 175 s without commands
// - After expiry need both fresh commands
// - Adapter-good released when sense above threshold
// - Adapter present needs supply and sense
// - Zero current or voltage disables charging
// - Supply below battery plus margin: power fail
// - Low interface supply holds reset, ignores traffic
// - After reset, charge only after both commands
// - Settings kept while interface supply good
// - All supply conditions together permit charging
// - Both gate drives low while charger off
// - Current write code 0x14 restarts watchdog
`timescale 1ns/1ps
`default_nettype none

module charge_enable_supervisor #(
	parameter int TICK_CYCLES = ces_pkg::TICK_CYCLES,
	parameter int WDOG_TICKS  = ces_pkg::WDOG_TICKS
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Decoded word writes from the management interface
	input  wire logic        cmdValid,
	input  wire logic [7:0]  cmdCode,
	input  wire logic [15:0] cmdData,
	output wire logic        cmdAccept,
	// Comparator results, asynchronous levels
	input  wire logic        adapterSupplyAbove4v,
	input  wire logic        adapterSenseAbove2v4,
	input  wire logic        gateDriveRailAbove4v,
	input  wire logic        referenceAbove3v1,
	input  wire logic        supplyMarginAbove150mv,
	input  wire logic        supplyMarginAbove250mv,
	input  wire logic        interfaceSupplyGood,
	// Converter request and pins
	input  wire logic        switchRequest,
	output var  logic        highSideDrive,
	output var  logic        lowSideDrive,
	output var  logic        adapterGoodOut,
	output var  logic        adapterGoodOe,
	// Status
	output var  logic        chargeEnable,
	output var  logic        adapterPresent,
	output var  logic        powerFail,
	output var  logic        watchdogExpired,
	output var  logic [15:0] chargeCurrentSetting,
	output var  logic [15:0] chargeVoltageSetting
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [6:0] syncIn;
	logic       supplyOk;
	logic       senseOk;
	logic       railOk;
	logic       refOk;
	logic       margin150;
	logic       margin250;
	logic       ifaceOk;

	ces_sync u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.async ({adapterSupplyAbove4v, adapterSenseAbove2v4,
		         gateDriveRailAbove4v, referenceAbove3v1,
		         supplyMarginAbove150mv, supplyMarginAbove250mv,
		         interfaceSupplyGood}),
		.synced(syncIn)
	);

	assign supplyOk  = syncIn[6];
	assign senseOk   = syncIn[5];
	assign railOk    = syncIn[4];
	assign refOk     = syncIn[3];
	assign margin150 = syncIn[2];
	assign margin250 = syncIn[1];
	assign ifaceOk   = syncIn[0];

	// Interface supply undervoltage acts as a register reset
	logic regReset;
	assign regReset = !rst_b || !ifaceOk;

	// ****************************************
	// Command decode
	// ****************************************
	logic currentWrite;
	logic voltageWrite;

	function automatic logic isCode(input logic [7:0] code,
	                                input logic [7:0] want);
		isCode = (code == want);
	endfunction

	// Traffic ignored while the interface supply is low
	assign cmdAccept    = cmdValid && !regReset;
	assign currentWrite = cmdAccept &&
		isCode(cmdCode, ces_pkg::CMD_CHARGE_CURRENT);
	assign voltageWrite = cmdAccept &&
		isCode(cmdCode, ces_pkg::CMD_CHARGE_VOLTAGE);

	// ****************************************
	// Setting registers
	// ****************************************
	// Unused bits are stored as zero
	always_ff @(posedge clk) begin
		if (regReset) begin
			chargeCurrentSetting <= ces_pkg::SETTING_RESET;
		end else if (currentWrite) begin
			chargeCurrentSetting <= {3'h0,
				cmdData[ces_pkg::CUR_FIELD_MSB:ces_pkg::CUR_FIELD_LSB],
				7'h00};
		end
	end

	always_ff @(posedge clk) begin
		if (regReset) begin
			chargeVoltageSetting <= ces_pkg::SETTING_RESET;
		end else if (voltageWrite) begin
			chargeVoltageSetting <= {1'h0,
				cmdData[ces_pkg::VOLT_FIELD_MSB:ces_pkg::VOLT_FIELD_LSB],
				4'h0};
		end
	end

	// ****************************************
	// Watchdog
	// ****************************************
	logic wdogExpiredRaw;
	logic wdogKick;
	logic expireNow;

	// ****************************************
	// Fresh command tracking
	// ****************************************
	logic gotCurrent;
	logic gotVoltage;

	// Only the raw watchdog flag clears, masked by a kick; clearing on the sticky flag would
	// throw away the first resent command before the second arrives
	assign expireNow = wdogExpiredRaw && !wdogKick;

	always_ff @(posedge clk) begin
		if (regReset) begin
			gotCurrent <= 1'b0;
			gotVoltage <= 1'b0;
		end else begin
			gotCurrent <= currentWrite ||
				(gotCurrent && !expireNow);
			gotVoltage <= voltageWrite ||
				(gotVoltage && !expireNow);
		end
	end

	assign wdogKick = currentWrite || voltageWrite;

	ces_watchdog #(
		.TICK_CYCLES (TICK_CYCLES),
		.WDOG_TICKS  (WDOG_TICKS)
	) u_wdog (
		.clk     (clk),
		.rst_b   (!regReset),
		.kick    (wdogKick),
		.expired (wdogExpiredRaw)
	);

	// Sticky until both commands are resent
	always_ff @(posedge clk) begin
		if (regReset) begin
			watchdogExpired <= 1'b0;
		end else if (expireNow) begin
			watchdogExpired <= 1'b1;
		end else if (gotCurrent && gotVoltage) begin
			watchdogExpired <= 1'b0;
		end
	end

	// ****************************************
	// Supply qualification
	// ****************************************
	logic marginOk;

	// Hysteresis: enter on the rising margin, hold on the falling one
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			marginOk <= 1'b0;
		end else if (margin250) begin
			marginOk <= 1'b1;
		end else if (!margin150) begin
			marginOk <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			adapterPresent <= 1'b0;
			powerFail      <= 1'b1;
			adapterGoodOut <= 1'b0;
			adapterGoodOe  <= 1'b1;
		end else begin
			adapterPresent <= supplyOk && senseOk;
			powerFail      <= !margin150;
			adapterGoodOut <= 1'b0;
			adapterGoodOe  <= !senseOk;
		end
	end

	// ****************************************
	// Charge enable and gate drive
	// ****************************************
	logic suppliesOk;
	logic settingsOk;

	assign suppliesOk = supplyOk && senseOk && railOk && refOk &&
		marginOk && ifaceOk && margin150;
	assign settingsOk = (chargeCurrentSetting != 16'h0000) &&
		(chargeVoltageSetting != 16'h0000);

	always_ff @(posedge clk) begin
		if (regReset) begin
			chargeEnable <= 1'b0;
		end else begin
			chargeEnable <= suppliesOk && settingsOk && gotCurrent &&
				gotVoltage && !watchdogExpired &&
				!expireNow;
		end
	end

	// Complementary drive; both low while disabled
	always_ff @(posedge clk) begin
		if (regReset) begin
			highSideDrive <= 1'b0;
			lowSideDrive  <= 1'b0;
		end else begin
			highSideDrive <= chargeEnable && switchRequest;
			lowSideDrive  <= chargeEnable && !switchRequest;
		end
	end

endmodule

`default_nettype wire

// >>> sim/ces_checker.sv
`timescale 1ns/1ps
`default_nettype none

module ces_checker #(
	parameter int TICK_CYCLES = 4,
	parameter int WDOG_TICKS  = 10
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_b,
	// Watched ports
	input wire logic        cmdAccept,
	input wire logic [7:0]  cmdCode,
	input wire logic [15:0] cmdData,
	input wire logic        adapterSenseAbove2v4,
	input wire logic        supplyMarginAbove150mv,
	input wire logic        interfaceSupplyGood,
	input wire logic        highSideDrive,
	input wire logic        lowSideDrive,
	input wire logic        adapterGoodOe,
	input wire logic        chargeEnable,
	input wire logic        powerFail,
	input wire logic        watchdogExpired,
	input wire logic [15:0] chargeCurrentSetting,
	input wire logic [15:0] chargeVoltageSetting
);
	localparam int LIMIT = TICK_CYCLES * WDOG_TICKS;
	int        idle;
	logic      gotCur;
	logic      gotVolt;
	wire logic kick = cmdAccept && (cmdCode == 8'h14 || cmdCode == 8'h15);

	always_ff @(posedge clk) begin
		if (!rst_b || kick)
			idle <= 0;
		else
			idle <= idle + 1;
	end

	// A write at the expiry edge still counts as fresh
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			gotCur  <= 1'b0;
			gotVolt <= 1'b0;
		end else begin
			gotCur  <= gotCur && !$rose(watchdogExpired) || kick && !cmdCode[0];
			gotVolt <= gotVolt && !$rose(watchdogExpired) || kick && cmdCode[0];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_start;
		$rose(chargeEnable);
	endsequence

	a_gate_off: assert property (!chargeEnable |=> !highSideDrive && !lowSideDrive)
		else $error("gate drive active while charger off");
	a_ok_release: assert property ((adapterSenseAbove2v4 && interfaceSupplyGood)[*4] |-> !adapterGoodOe)
		else $error("adapter good still driven low");
	a_ok_drive: assert property ((!adapterSenseAbove2v4)[*4] |-> adapterGoodOe)
		else $error("adapter good not driven low");
	a_fail_blocks: assert property ((!supplyMarginAbove150mv)[*5] |-> powerFail && !chargeEnable)
		else $error("charging during power fail");
	a_uv_refuse: assert property ((!interfaceSupplyGood)[*3] |-> !cmdAccept)
		else $error("write taken in undervoltage");
	a_cur_mask: assert property (kick && cmdCode == 8'h14 |=> chargeCurrentSetting == ($past(cmdData) & 16'h1f80))
		else $error("current setting wrong after write");
	a_zero_off: assert property (chargeCurrentSetting == 16'h0000 || chargeVoltageSetting == 16'h0000 |=> !chargeEnable)
		else $error("charging with a zero setting");
	a_dog_stop: assert property (idle > LIMIT + 3 |-> !chargeEnable)
		else $error("charging after watchdog time");
	a_dog_early: assert property (idle < LIMIT - 2 |-> !$rose(watchdogExpired))
		else $error("watchdog expired too early");
	a_needs_both: assert property (s_start |-> gotCur && gotVolt)
		else $error("charging without both commands");
endmodule

bind charge_enable_supervisor ces_checker #(
	.TICK_CYCLES(TICK_CYCLES),
	.WDOG_TICKS(WDOG_TICKS)
) chk_i (.*);

`default_nettype wire

// >>> sim/ces_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module ces_host_model (
	// Clock
	input  wire logic        clk,
	// Word writes
	output var  logic        cmdValid,
	output var  logic [7:0]  cmdCode,
	output var  logic [15:0] cmdData
);
	initial begin
		cmdValid = 1'b0;
		cmdCode  = 8'h00;
		cmdData  = 16'h0000;
	end

	// Host writes start charging; supply faults and the watchdog can also stop it
	task automatic send(input logic [7:0] code, input logic [15:0] data);
		@(posedge clk);
		#1;
		cmdValid = 1'b1;
		cmdCode  = code;
		cmdData  = data;
		@(posedge clk);
		#1;
		cmdValid = 1'b0;
		// Released lines show the inverse so stale data is never reused
		cmdCode  = ~code;
		cmdData  = ~data;
	endtask
endmodule

`default_nettype wire

// >>> sim/charge_enable_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none

module charge_enable_supervisor_tb;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cmdValid, cmdAccept;
	logic [7:0]  cmdCode;
	logic [15:0] cmdData, chargeCurrentSetting, chargeVoltageSetting;
	logic adapterSupplyAbove4v = 1, adapterSenseAbove2v4 = 1;
	logic gateDriveRailAbove4v = 1, referenceAbove3v1 = 1;
	logic supplyMarginAbove150mv = 1, supplyMarginAbove250mv = 1;
	logic interfaceSupplyGood = 1, switchRequest = 0;
	logic highSideDrive, lowSideDrive, adapterGoodOut, adapterGoodOe;
	logic chargeEnable, adapterPresent, powerFail, watchdogExpired;
	int   err_total = 0;
	int   num_checks = 0;

	always #10 clk = ~clk;
	ces_host_model host (.*);
	charge_enable_supervisor #(.TICK_CYCLES(4), .WDOG_TICKS(10)) dut (.*);

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Bounded wait for the charge decision to settle
	task automatic wait_en(input logic v);
		for (int i = 0; i < 200 && chargeEnable !== v; i++)
			tick(1);
		chk(16'(chargeEnable), 16'(v));
		if (chargeEnable !== v)
			give_verdict();
	endtask

	initial begin
		tick(2);
		chk({12'h000, powerFail, adapterGoodOe, highSideDrive, lowSideDrive}, 16'h000c);
		chk(chargeCurrentSetting, 16'h0000);
		rst_b = 1'b1;
		tick(3);
		host.send(8'h14, 16'hffff);
		tick(6);
		chk(chargeCurrentSetting, 16'h1f80);
		chk(16'(chargeEnable), 16'h0000);
		host.send(8'h15, 16'hffff);
		wait_en(1'b1);
		chk(chargeVoltageSetting, 16'h7ff0);
		switchRequest = 1'b1;
		tick(4);
		chk({14'h0000, highSideDrive, lowSideDrive}, 16'h0002);
		host.send(8'h3f, 16'h0000);
		tick(3);
		chk(chargeCurrentSetting, 16'h1f80);
		host.send(8'h14, 16'h0000);
		wait_en(1'b0);
		host.send(8'h14, 16'h0080);
		wait_en(1'b1);
		repeat (3) begin
			tick(30);
			host.send(8'h15, 16'h0010);
		end
		chk({14'h0000, chargeEnable, watchdogExpired}, 16'h0002);
		wait_en(1'b0);
		chk(16'(watchdogExpired), 16'h0001);
		host.send(8'h14, 16'h1000);
		tick(6);
		chk(16'(chargeEnable), 16'h0000);
		host.send(8'h15, 16'h4000);
		wait_en(1'b1);
		adapterSenseAbove2v4 = 1'b0;
		tick(5);
		chk({14'h0000, adapterGoodOe, adapterPresent}, 16'h0002);
		wait_en(1'b0);
		adapterSenseAbove2v4 = 1'b1;
		host.send(8'h15, 16'h4000);
		wait_en(1'b1);
		chk({14'h0000, adapterGoodOe, adapterPresent}, 16'h0001);
		supplyMarginAbove150mv = 1'b0;
		supplyMarginAbove250mv = 1'b0;
		tick(5);
		chk({14'h0000, powerFail, chargeEnable}, 16'h0002);
		supplyMarginAbove150mv = 1'b1;
		tick(5);
		chk({14'h0000, powerFail, chargeEnable}, 16'h0000);
		supplyMarginAbove250mv = 1'b1;
		host.send(8'h15, 16'h4000);
		wait_en(1'b1);
		referenceAbove3v1 = 1'b0;
		wait_en(1'b0);
		referenceAbove3v1 = 1'b1;
		chk(chargeVoltageSetting, 16'h4000);
		interfaceSupplyGood = 1'b0;
		tick(4);
		host.send(8'h14, 16'hffff);
		tick(2);
		chk(chargeCurrentSetting, 16'h0000);
		interfaceSupplyGood = 1'b1;
		tick(4);
		host.send(8'h14, 16'hffff);
		tick(6);
		chk(16'(chargeEnable), 16'h0000);
		give_verdict();
	end
endmodule

`default_nettype wire
